// ### hdl/ldpfc_top.sv
// Purpose: LED dimming generator and latched fault control, six sinks.
// Assumes: Comparator flags and pins are synchronous to clk_i.
// Notes: Registers are reached over an AHB-Lite slave, zero wait.
//   Latched faults clear only on reset or a rising edge of enable.
`timescale 1ns/1ps
// How it works
// - Programmable mode measures input duty into eight bits for the generator.
// - Programmable mode switches all six sinks together at set frequency.
// - Direct mode makes every sink follow the dimming input.
// - The duty decoder is held idle in direct mode.
// - Strap tied to supply selects direct; otherwise programmable.
// - Dimming period register sets the programmable dimming frequency.
// - A channel sensing no current is latched off and left out.
// - A channel above the sink overvoltage level is latched off.
// - The device shuts down for open strings only when all open.
// - Disabled channels stay off until reset or enable toggle.
// - Switch current at limit blocks the switch until next cycle.
// - Sustained overcurrent latches the device off.
// - Output short latches the device off at once.
// - Overtemperature latches the device off at once.
// - Output sense over clamp level inhibits further boost rise.
// - At startup, channels found unused are shut down.
// - With the dimming input floating, output is held at minimum.
module ldpfc_top
  import ldpfc_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Host pins and strap
  input wire logic enable_i,
  input wire logic dimming_pulse_input_i,
  input wire logic dim_input_present_i,
  input wire logic dim_freq_mode_strap_i,
  // Analogue comparator flags
  input wire logic [CH-1:0] sink_no_current_i,
  input wire logic [CH-1:0] sink_over_volt_i,
  input wire logic output_voltage_sense_over_i,
  input wire logic sw_cycle_start_i,
  input wire ldpfc_fault_t fault_i,
  // Power stage controls
  output logic [CH-1:0] sink_on_o,
  output logic power_switch_en_o,
  output logic boost_inhibit_o,
  output logic min_voltage_o,
  output logic shutdown_o
);

  if (CH < 1 || CH > 8) begin : g_chk
    $error("ldpfc_top: CH must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Sequencing and mode.
  ldpfc_state_t state_r;
  ldpfc_state_t state_nxt;
  logic en_d_r;
  logic direct_r;
  // Latched faults and channel masks.
  logic [CH-1:0] ch_off_r;
  logic [CH-1:0] ch_open_r;
  logic temp_r;
  logic short_r;
  logic sust_oc_r;
  logic sw_block_r;
  // Dimming generator and power-stage controls.
  logic [PER_W-1:0] period_r;
  logic [PER_W-1:0] dim_cnt_r;
  logic [CH-1:0] sink_on_r;
  logic pse_r;
  logic inhibit_r;
  logic minv_r;
  logic shut_r;
  // Bus slave.
  logic ph_wr_r;
  logic [7:0] ph_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_sel;
  logic hreadyout_r;
  logic hresp_r;
  // Decoder result.
  logic [DUTY_W-1:0] duty;
  logic duty_valid;

  // ---------------------------------------------------------------
  // Enable edge, fault summary and mode
  // ---------------------------------------------------------------
  // Enable held high through reset counts as a rise on the first cycle.
  wire en_rise = enable_i & ~en_d_r;
  wire all_open = &ch_open_r;
  wire latched = temp_r | short_r | sust_oc_r | all_open;
  wire running = state_r == ST_ACTIVE;
  wire prog_mode = ~direct_r;
  wire [CH-1:0] open_evt = running ? sink_no_current_i : '0;
  wire [CH-1:0] ov_evt = running ? sink_over_volt_i : '0;

  // Startup check, run and shutdown sequencing.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_rise) state_nxt = ST_CHECK;
      end
      ST_CHECK: begin
        state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (latched) state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!enable_i) state_nxt = ST_OFF;
  end

  // Registered state, enable history and mode strap.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      en_d_r <= 1'b0;
      direct_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      en_d_r <= enable_i;
      direct_r <= dim_freq_mode_strap_i;
    end
  end

  // ---------------------------------------------------------------
  // Latched faults: an event in the clear cycle still sets the flag.
  // ---------------------------------------------------------------
  wire [CH-1:0] unused_evt = (state_r == ST_CHECK) ? sink_no_current_i : '0;

  // Next value of a latched flag: a set in the clear cycle still wins.
  function automatic logic latch_nxt(input logic q, input logic clr,
                                     input logic set);
    latch_nxt = (q & ~clr) | set;
  endfunction

  // Channel masks and device latches, cleared together by enable rise.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch_off_r <= '0;
      ch_open_r <= '0;
      temp_r <= 1'b0;
      short_r <= 1'b0;
      sust_oc_r <= 1'b0;
    end else begin
      ch_off_r <= (en_rise ? '0 : ch_off_r)
                  | open_evt | ov_evt | unused_evt;
      ch_open_r <= (en_rise ? '0 : ch_open_r) | open_evt | unused_evt;
      temp_r <= latch_nxt(temp_r, en_rise, fault_i.over_temp);
      short_r <= latch_nxt(short_r, en_rise, fault_i.output_short);
      sust_oc_r <= latch_nxt(sust_oc_r, en_rise,
                             fault_i.sustained_oc);
    end
  end

  // Pulse-by-pulse limit: the limit wins if it meets a cycle start.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_block_r <= 1'b0;
    end else begin
      sw_block_r <= latch_nxt(sw_block_r, sw_cycle_start_i,
                              fault_i.sw_over_limit);
    end
  end

  // ---------------------------------------------------------------
  // Duty decoder, idle in direct mode
  // ---------------------------------------------------------------
  // While idle the decoder keeps its last result, so a return to
  // programmable mode replays the old duty until a period is measured.
  ldpfc_duty_decoder #(
    .CNT_W(PER_W)
  ) u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(prog_mode & enable_i),
    .pulse_i(dimming_pulse_input_i),
    .duty_o(duty),
    .valid_o(duty_valid)
  );

  // ---------------------------------------------------------------
  // Output dimming generator
  // ---------------------------------------------------------------
  wire [PER_W+DUTY_W-1:0] on_prod = period_r * duty;
  wire [PER_W-1:0] on_cnt = on_prod[PER_W+DUTY_W-1:DUTY_W];
  // The period register never holds less than 2, so the counter always
  // wraps; a shorter period written mid-count cuts that period short.
  wire dim_wrap = dim_cnt_r >= period_r - 1'b1;
  wire gen_on = (dim_cnt_r < on_cnt) & duty_valid;
  wire sig_ok = dim_input_present_i;
  wire dim_on = direct_r ? dimming_pulse_input_i : gen_on;
  // Sinks are off unless running, the input is present and dimming is on.
  wire [CH-1:0] sink_nxt =
    (running && sig_ok && dim_on) ? ~ch_off_r : '0;

  // Period counter and registered sink and power-stage controls.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dim_cnt_r <= '0;
      sink_on_r <= '0;
      pse_r <= 1'b0;
      inhibit_r <= 1'b0;
      minv_r <= 1'b0;
      shut_r <= 1'b1;
    end else begin
      dim_cnt_r <= dim_wrap ? '0 : dim_cnt_r + 1'b1;
      sink_on_r <= sink_nxt;
      pse_r <= running & ~sw_block_r & ~fault_i.sw_over_limit;
      inhibit_r <= output_voltage_sense_over_i;
      minv_r <= running & ~sig_ok;
      shut_r <= ~running;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY, word registers.
  // ---------------------------------------------------------------
  // An address phase is taken when selected, ready and NONSEQ or SEQ.
  wire ahb_go = hsel_i & hready_i & htrans_i[1];
  wire rd_go = ahb_go & ~hwrite_i;
  wire [PER_W-1:0] wr_per = hwdata_i[PER_W-1:0];
  wire [31:0] st_word = {24'h000000, inhibit_r, all_open, sust_oc_r,
                         short_r, temp_r, running, sig_ok, direct_r};
  wire [31:0] ch_word = {16'h0000, {(8-CH){1'b0}}, ch_open_r,
                         {(8-CH){1'b0}}, ch_off_r};
  wire [7:0] rd_addr = haddr_i[7:0];
  wire addr_hi_ok = haddr_i[31:8] == 24'h000000;

  // Read data is loaded at the address phase so it stands in the data phase.
  always_comb begin
    case (rd_addr)
      REG_PERIOD: rdata_sel = {{(32-PER_W){1'b0}}, period_r};
      REG_STATUS: rdata_sel = st_word;
      REG_CHAN: rdata_sel = ch_word;
      REG_DUTY: rdata_sel = {{(32-DUTY_W){1'b0}}, duty};
      default: rdata_sel = 32'h00000000;
    endcase
    if (!addr_hi_ok) rdata_sel = 32'h00000000;
  end

  // Bus phase registers; the response is always OKAY.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
      hreadyout_r <= 1'b0;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if (hready_i) begin
        ph_wr_r <= ahb_go & hwrite_i & addr_hi_ok;
        ph_addr_r <= rd_addr;
      end
      if (rd_go) rdata_r <= rdata_sel;
    end
  end

  // A write lands in its data phase, one cycle after the address phase.
  wire per_wr_go = ph_wr_r && (ph_addr_r == REG_PERIOD);

  // Dimming period register, clamped so the counter always wraps.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      period_r <= PERIOD_RST;
    end else if (per_wr_go) begin
      period_r <= (wr_per < PERIOD_MIN) ? PERIOD_MIN : wr_per;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is driven straight from a register.
  assign hrdata_o = rdata_r;
  assign hreadyout_o = hreadyout_r;
  assign hresp_o = hresp_r;
  assign sink_on_o = sink_on_r;
  assign power_switch_en_o = pse_r;
  assign boost_inhibit_o = inhibit_r;
  assign min_voltage_o = minv_r;
  assign shutdown_o = shut_r;

endmodule

// ### hdl/ldpfc_pkg.sv
// Purpose: Shared constants and types of the LED dimming and fault block.
// Assumes: One 125 MHz clock; the AHB-Lite slave has 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
package ldpfc_pkg;

  // ---------------------------------------------------------------
  // Sizes and clock
  // ---------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int DUTY_W = 8;
  localparam int PER_W = 24;
  localparam longint CLK_HZ = 125000000;

  // ---------------------------------------------------------------
  // Dimming frequency: the strap resistor law gives Hz = K / ohms.
  // ---------------------------------------------------------------
  localparam longint FREQ_K_OHM_HZ = 181800000;
  localparam longint DEF_RES_OHM = 9090;
  localparam longint DEF_FREQ_HZ = FREQ_K_OHM_HZ / DEF_RES_OHM;
  localparam logic [PER_W-1:0] PERIOD_RST =
    PER_W'(CLK_HZ / DEF_FREQ_HZ);
  localparam logic [PER_W-1:0] PERIOD_MIN = 24'h000002;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_PERIOD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHAN = 8'h08;
  localparam logic [7:0] REG_DUTY = 8'h0C;
  localparam int ST_DIRECT = 0;
  localparam int ST_PRESENT = 1;
  localparam int ST_RUN = 2;
  localparam int ST_TEMP = 3;
  localparam int ST_SHORT = 4;
  localparam int ST_SUST_OC = 5;
  localparam int ST_ALL_OPEN = 6;
  localparam int ST_CLAMP = 7;
  localparam int CH_OPEN_LSB = 8;

  // ---------------------------------------------------------------
  // Power-stage fault indications from the analogue comparators.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic over_temp;
    logic output_short;
    logic sustained_oc;
    logic sw_over_limit;
  } ldpfc_fault_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CHECK,
    ST_ACTIVE
  } ldpfc_state_t;

endpackage

// ### hdl/ldpfc_duty_decoder.sv
// Purpose: Measures the duty cycle of the dimming input as 8 bits.
// Assumes: The dimming input is synchronous to clk_i.
// Notes: Result = floor(high * 256 / period), held at 255 when full.
`timescale 1ns/1ps
module ldpfc_duty_decoder
  import ldpfc_pkg::*;
#(
  parameter int CNT_W = PER_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control and input
  input wire logic enable_i,
  input wire logic pulse_i,
  // Result
  output logic [DUTY_W-1:0] duty_o,
  output logic valid_o
);

  if (CNT_W < 4 || CNT_W > 30) begin : g_chk
    $error("ldpfc_duty_decoder: CNT_W out of range");
  end

  logic pulse_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] high_r;
  logic [CNT_W-1:0] hi_cap_r;
  logic [CNT_W-1:0] per_cap_r;
  logic [CNT_W:0] rem_r;
  logic [DUTY_W-1:0] quo_r;
  logic [3:0] step_r;
  logic [DUTY_W-1:0] duty_r;
  logic valid_r;

  // Edge detection and the restoring divider step.
  wire rise = pulse_i & ~pulse_d_r;
  wire cnt_full = &cnt_r;
  wire [CNT_W:0] rem_sh = {rem_r[CNT_W-1:0], 1'b0};
  wire take = rem_sh >= {1'b0, per_cap_r};
  wire [CNT_W:0] rem_nxt = take ? rem_sh - {1'b0, per_cap_r} : rem_sh;
  wire full_on = hi_cap_r == per_cap_r;

  // Counts the period and the high time, then divides over 8 steps.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_d_r <= 1'b0;
      cnt_r <= '0;
      high_r <= '0;
      hi_cap_r <= '0;
      per_cap_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      step_r <= 4'h0;
      duty_r <= '0;
      valid_r <= 1'b0;
    end else if (!enable_i) begin
      pulse_d_r <= 1'b0;
      cnt_r <= '0;
      high_r <= '0;
      step_r <= 4'h0;
    end else begin
      pulse_d_r <= pulse_i;
      if (rise) begin
        if (cnt_r != '0) begin
          per_cap_r <= cnt_r;
          hi_cap_r <= high_r;
          rem_r <= {1'b0, high_r};
          step_r <= 4'h8;
        end
        cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
        high_r <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        if (!cnt_full) cnt_r <= cnt_r + 1'b1;
        if (pulse_i && !cnt_full) high_r <= high_r + 1'b1;
      end
      if (step_r != 4'h0) begin
        rem_r <= rem_nxt;
        quo_r <= {quo_r[DUTY_W-2:0], take};
        step_r <= step_r - 4'h1;
        if (step_r == 4'h1) begin
          duty_r <= full_on ? {DUTY_W{1'b1}} :
                    {quo_r[DUTY_W-2:0], take};
          valid_r <= 1'b1;
        end
      end
    end
  end

  assign duty_o = duty_r;
  assign valid_o = valid_r;

endmodule

// ### test/ldpfc_chk.sv
// Purpose: Port checker of the dimming and fault block.
// Assumes: One clock; rst_i is asynchronous and active high.
// Notes: Bound into ldpfc_top at the foot of this file.
`timescale 1ns/1ps
module ldpfc_chk
  import ldpfc_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched pins
  input wire logic enable_i,
  input wire logic dim_freq_mode_strap_i,
  input wire logic dimming_pulse_input_i,
  input wire logic [CH-1:0] sink_no_current_i,
  input wire logic output_voltage_sense_over_i,
  input wire logic sw_cycle_start_i,
  input wire ldpfc_fault_t fault_i,
  input wire logic [CH-1:0] sink_on_o,
  input wire logic power_switch_en_o,
  input wire logic boost_inhibit_o,
  input wire logic shutdown_o
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // A latching power-stage fault, and a limit hit with no new cycle.
  sequence s_hard_fault;
    fault_i.over_temp || fault_i.output_short || fault_i.sustained_oc;
  endsequence
  sequence s_limit_quiet;
    fault_i.sw_over_limit ##1
      (!sw_cycle_start_i && !fault_i.sw_over_limit)[*3];
  endsequence

  chk_clamp_rise: assert property (
    output_voltage_sense_over_i |=> boost_inhibit_o)
    else $error("boost not inhibited after sense over level");
  chk_clamp_fall: assert property (
    !output_voltage_sense_over_i |=> !boost_inhibit_o)
    else $error("boost inhibited without sense over level");
  chk_direct_low: assert property (
    $past(dim_freq_mode_strap_i, 2) && $past(dim_freq_mode_strap_i)
    && !$past(dimming_pulse_input_i) |-> sink_on_o == '0)
    else $error("sink on while direct input was low");
  chk_fault_stop: assert property (
    s_hard_fault |-> ##[1:3] shutdown_o)
    else $error("no shutdown after latching fault");
  chk_stays_off: assert property (
    shutdown_o && !enable_i |=> shutdown_o)
    else $error("left shutdown without enable");
  chk_enable_low: assert property (
    $fell(enable_i) |-> ##[1:2] shutdown_o)
    else $error("enable low did not shut down");
  chk_start_up: assert property (
    $rose(enable_i) && fault_i == '0 && sink_no_current_i == '0
    |-> ##[1:3] !shutdown_o)
    else $error("no start after enable rise");
  chk_limit_cut: assert property (
    fault_i.sw_over_limit |-> ##[1:2] !power_switch_en_o)
    else $error("switch not cut at current limit");
  chk_limit_hold: assert property (
    s_limit_quiet |-> !power_switch_en_o)
    else $error("switch back before next cycle");
  chk_open_off: assert property (
    !shutdown_o && sink_no_current_i != '0
    |-> ##3 (sink_on_o & $past(sink_no_current_i, 3)) == '0)
    else $error("open channel still sinking");
  chk_all_open: assert property (
    !shutdown_o && &sink_no_current_i |-> ##[1:3] shutdown_o)
    else $error("no shutdown with all strings open");
endmodule

bind ldpfc_top ldpfc_chk #(.CH(CH)) ldpfc_chk_inst (
  .clk_i, .rst_i, .enable_i, .dim_freq_mode_strap_i,
  .dimming_pulse_input_i, .sink_no_current_i,
  .output_voltage_sense_over_i, .sw_cycle_start_i, .fault_i,
  .sink_on_o, .power_switch_en_o, .boost_inhibit_o, .shutdown_o);

// ### test/ldpfc_host_pwm.sv
// Purpose: Host brightness source driving enable and dimming pulses.
// Assumes: Every pin changes just after a rising edge of clk_i.
// Notes: A released dimming line toggles each cycle, never holds.
`timescale 1ns/1ps
module ldpfc_host_pwm (
  // Clock and bench controls
  input wire logic clk_i,
  input wire logic en_req_i,
  input wire logic run_i,
  input wire logic [15:0] period_i,
  input wire logic [15:0] high_i,
  // Pins toward the device
  output logic enable_o,
  output logic pulse_o,
  output logic present_o
);
  logic [15:0] cnt_r = 16'h0000;

  // Start with the device held in shutdown.
  initial begin
    enable_o = 1'b0;
    pulse_o = 1'b0;
    present_o = 1'b0;
  end

  // Host enable, and a pulse train high for high_i of period_i.
  always @(posedge clk_i) begin
    enable_o <= en_req_i;
    present_o <= run_i;
    cnt_r <= (cnt_r + 16'h0001 >= period_i) ? 16'h0000 : cnt_r + 16'h0001;
    pulse_o <= run_i ? (cnt_r < high_i) : !pulse_o;
  end
endmodule

// ### test/ldpfc_top_tb.sv
// Purpose: Self-checking bench of the dimming and fault block.
// Assumes: 125 MHz clock; zero-wait AHB-Lite slave.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module ldpfc_top_tb
  import ldpfc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, en_req = 1'b0, run = 1'b0;
  logic strap = 1'b0, sense = 1'b0, cyc_start = 1'b0, prev;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] per = 16'h0040, hi = 16'h0010;
  logic [5:0] nc = 6'h00, ov = 6'h00, sink_on;
  ldpfc_fault_t flt = '0;
  logic hready, hresp, enable, pulse, present, sw_en, inh, minv, sd;
  int mismatches = 0, tests_run = 0, cnt;

  // Clock of 8 ns period.
  always #4 clk = ~clk;

  // Device under test and the host source.
  ldpfc_top ldpfc_top_inst (.clk_i(clk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .enable_i(enable), .dimming_pulse_input_i(pulse),
    .dim_input_present_i(present), .dim_freq_mode_strap_i(strap),
    .sink_no_current_i(nc), .sink_over_volt_i(ov),
    .output_voltage_sense_over_i(sense), .sw_cycle_start_i(cyc_start),
    .fault_i(flt), .sink_on_o(sink_on), .power_switch_en_o(sw_en),
    .boost_inhibit_o(inh), .min_voltage_o(minv), .shutdown_o(sd));
  ldpfc_host_pwm ldpfc_host_pwm_inst (.clk_i(clk), .en_req_i(en_req),
    .run_i(run), .period_i(per), .high_i(hi), .enable_o(enable),
    .pulse_o(pulse), .present_o(present));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // One single AHB transfer; read data lands in q.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    q = hrdata;
  endtask
  // Toggle enable with mask m of dead channels during the check.
  task automatic restart(input logic [5:0] m);
    en_req <= 1'b0;
    nc <= m;
    cyc(4);
    en_req <= 1'b1;
    cyc(4);
    nc <= 6'h00;
    cyc(6);
  endtask

  task automatic t_regs;
    ahb(1'b0, REG_PERIOD, 32'h0);
    `CHK(q, {8'h00, PERIOD_RST})
    `CHK(hresp, 1'b0)
    ahb(1'b1, REG_PERIOD, 32'h1);
    ahb(1'b0, REG_PERIOD, 32'h0);
    `CHK(q, {8'h00, PERIOD_MIN})
    ahb(1'b1, REG_PERIOD, 32'h64);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_DIRECT], 1'b0)
    done("regs");
  endtask

  task automatic t_prog;
    restart(6'h00);
    @(negedge clk);
    `CHK(minv, 1'b1)
    cyc(1);
    run <= 1'b1;
    cyc(400);
    @(negedge clk);
    `CHK(minv, 1'b0)
    ahb(1'b0, REG_DUTY, 32'h0);
    `CHK(q, 32'h40)
    cnt = 0;
    repeat (400) begin
      @(negedge clk);
      if (sink_on === 6'h3F) cnt++;
      else `CHK(sink_on, 6'h00)
    end
    `CHK(cnt, 4 * ((100 * 64) >> 8))
    done("programmable");
  endtask

  task automatic t_direct;
    cyc(1);
    hi <= 16'h0003;
    per <= 16'h000A;
    strap <= 1'b1;
    cyc(20);
    @(negedge clk);
    prev = pulse;
    repeat (40) begin
      @(negedge clk);
      `CHK(sink_on, {6{prev}})
      prev = pulse;
    end
    ahb(1'b0, REG_DUTY, 32'h0);
    `CHK(q, 32'h40)
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_DIRECT], 1'b1)
    done("direct");
  endtask

  task automatic t_chan;
    hi <= 16'h000A;
    restart(6'h20);
    @(negedge clk);
    `CHK(sink_on, 6'h1F)
    cyc(1);
    nc <= 6'h01;
    ov <= 6'h02;
    cyc(2);
    nc <= 6'h00;
    ov <= 6'h00;
    cyc(4);
    @(negedge clk);
    `CHK(sink_on, 6'h1C)
    `CHK(sd, 1'b0)
    ahb(1'b0, REG_CHAN, 32'h0);
    `CHK(q[7:0], 8'h23)
    `CHK(q[9:8], 2'b01)
    restart(6'h00);
    @(negedge clk);
    `CHK(sink_on, 6'h3F)
    cyc(1);
    nc <= 6'h3F;
    cyc(5);
    nc <= 6'h00;
    @(negedge clk);
    `CHK(sd, 1'b1)
    ahb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_ALL_OPEN], 1'b1)
    done("channels");
  endtask

  task automatic t_faults;
    for (int i = 1; i < 4; i++) begin
      restart(6'h00);
      flt <= ldpfc_fault_t'(4'h1 << i);
      cyc(1);
      flt <= '0;
      cyc(6);
      @(negedge clk);
      `CHK(sd, 1'b1)
      ahb(1'b0, REG_STATUS, 32'h0);
      `CHK(q[6 - i], 1'b1)
    end
    restart(6'h00);
    flt <= ldpfc_fault_t'(4'h1);
    cyc(1);
    flt <= '0;
    cyc(4);
    @(negedge clk);
    `CHK(sw_en, 1'b0)
    cyc(1);
    cyc_start <= 1'b1;
    sense <= 1'b1;
    cyc(1);
    cyc_start <= 1'b0;
    @(negedge clk);
    `CHK(inh, 1'b1)
    cyc(3);
    sense <= 1'b0;
    @(negedge clk);
    `CHK(sw_en, 1'b1)
    done("faults");
  endtask

  // Verdict and end of run.
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly one thousand cycles the tests need.
  initial begin
    #400000;
    mismatches++;
    final_report;
  end

  // Reset for two cycles, then the scenarios in order.
  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    t_regs;
    t_prog;
    t_direct;
    t_chan;
    t_faults;
    final_report;
  end
endmodule
